// File: verilog/csb_unit.v
// compare, conditional skip and relative branch execution unit
`timescale 1ns/100ps
`include "csb_consts.vh"
module csb_unit (
    input  wire        clk,          // core clock
    input  wire        rst_b,        // async reset, active low
    input  wire        clk_en,       // freezes all state when low
    input  wire        ins_valid,    // one-cycle instruction strobe
    input  wire [3:0]  ins_op,       // operation select
    input  wire [7:0]  reg_d,        // first working register value
    input  wire [7:0]  reg_r,        // second register or immediate
    input  wire [7:0]  io_val,       // addressed I/O register value
    input  wire [2:0]  bit_sel,      // bit b or flag s
    input  wire [6:0]  offset_k,     // signed branch offset
    input  wire        next_two_word,// following instruction is two words
    input  wire [11:0] pc_in,        // address of this instruction
    output reg  [11:0] pc_q,         // next program counter
    output reg  [7:0]  status_flags_q,// status flags
    output reg  [1:0]  cycles_q,     // cycles taken by last instruction
    output reg         done_q,       // one-cycle completion pulse
    output wire        busy          // extra cycles in progress
);
    // instruction accept and wait-state sequencing
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;

    // registered state and next values
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [1:0]  wait_q;
    reg  [1:0]  wait_d;
    reg  [11:0] pc_d;
    reg  [7:0]  status_flags_d;
    reg  [1:0]  cycles_d;
    reg         done_d;

    // operation decode
    wire        op_skip_eq;
    wire        op_cmp_imm;
    wire        op_skip_rbc;
    wire        op_skip_rbs;
    wire        op_skip_ibc;
    wire        op_skip_ibs;
    wire        op_br_set;
    wire        op_br_clr;
    wire        op_known;
    wire        op_is_skip;
    wire        op_is_branch;
    wire        accept;

    // condition evaluation
    wire        reg_bit;
    wire        io_bit;
    wire        flag_bit;
    wire        ops_equal;
    reg         take;

    // target and cycle selection
    wire [11:0] k_ext;
    wire [11:0] skip_step;
    wire [11:0] pc_seq;
    wire [11:0] pc_skip;
    wire [11:0] pc_br;
    wire [1:0]  skip_cyc;
    reg  [11:0] target;
    reg  [1:0]  cyc;
    wire [7:0]  cmp_flags;

    csb_flag_calc u_flags (
        .op_a      (reg_d),
        .op_b      (reg_r),
        .flags_in  (status_flags_q),
        .flags_out (cmp_flags)
    );

    assign op_skip_eq   = (ins_op == `CSB_OP_SKIP_EQ);
    assign op_cmp_imm   = (ins_op == `CSB_OP_CMP_IMM);
    assign op_skip_rbc  = (ins_op == `CSB_OP_SKIP_RBC);
    assign op_skip_rbs  = (ins_op == `CSB_OP_SKIP_RBS);
    assign op_skip_ibc  = (ins_op == `CSB_OP_SKIP_IBC);
    assign op_skip_ibs  = (ins_op == `CSB_OP_SKIP_IBS);
    assign op_br_set    = (ins_op == `CSB_OP_BR_SET);
    assign op_br_clr    = (ins_op == `CSB_OP_BR_CLR);
    assign op_is_skip   = op_skip_eq | op_skip_rbc | op_skip_rbs | op_skip_ibc | op_skip_ibs;
    assign op_is_branch = op_br_set | op_br_clr;
    // unknown codes are dropped silently rather than trapped
    assign op_known     = op_is_skip | op_is_branch | op_cmp_imm;
    // requests during wait states are ignored; the core must not issue them
    assign accept       = ins_valid & op_known & (state_q == ST_IDLE);

    assign reg_bit   = reg_d[bit_sel];
    assign io_bit    = io_val[bit_sel];
    assign flag_bit  = status_flags_q[bit_sel];
    assign ops_equal = (reg_d == reg_r);

    assign k_ext     = {{5{offset_k[6]}}, offset_k};
    // skip moves past a one- or two-word follower
    assign skip_step = next_two_word ? `CSB_SKIP_TWO : `CSB_SKIP_ONE;
    assign skip_cyc  = next_two_word ? `CSB_CYC_SKIP_TWO : `CSB_CYC_SKIP_ONE;
    assign pc_seq    = pc_in + `CSB_PC_STEP;
    assign pc_skip   = pc_in + skip_step;
    assign pc_br     = pc_in + k_ext + `CSB_PC_STEP;
    assign busy      = (state_q == ST_WAIT);

    always @* begin
        take = 1'b0;
        if (op_skip_eq) begin
            take = ops_equal;
        end
        if (op_skip_rbc) begin
            take = ~reg_bit;
        end
        if (op_skip_rbs) begin
            take = reg_bit;
        end
        if (op_skip_ibc) begin
            take = ~io_bit;
        end
        if (op_skip_ibs) begin
            take = io_bit;
        end
        if (op_br_set) begin
            take = flag_bit;
        end
        if (op_br_clr) begin
            take = ~flag_bit;
        end
    end

    always @* begin
        target = pc_seq;
        cyc    = `CSB_CYC_SEQ;
        if (take && op_is_branch) begin
            target = pc_br;
            cyc    = `CSB_CYC_BR;
        end else if (take && op_is_skip) begin
            target = pc_skip;
            cyc    = skip_cyc;
        end
    end

    always @* begin
        state_d        = state_q;
        wait_d         = wait_q;
        pc_d           = pc_q;
        status_flags_d = status_flags_q;
        cycles_d       = cycles_q;
        done_d         = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (accept) begin
                    pc_d     = target;
                    cycles_d = cyc;
                    // flags only, difference is discarded
                    if (op_cmp_imm) begin
                        status_flags_d = cmp_flags;
                    end
                    if (cyc == `CSB_CYC_SEQ) begin
                        done_d = 1'b1;
                    end else begin
                        wait_d  = cyc - 2'h1;
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // extra cycles model the flushed fetch after a taken skip or a taken branch
                wait_d = wait_q - 2'h1;
                if (wait_q == 2'h1) begin
                    done_d  = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 2'h0;
        end else if (clk_en) begin
            wait_q <= wait_d;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q <= `CSB_PC_RST;
        end else if (clk_en) begin
            pc_q <= pc_d;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_flags_q <= `CSB_FLAGS_RST;
        end else if (clk_en) begin
            status_flags_q <= status_flags_d;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cycles_q <= `CSB_CYC_RST;
        end else if (clk_en) begin
            cycles_q <= cycles_d;
        end
    end

    // done pulse is held, not repeated, while the clock enable is low
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= 1'b0;
        end else if (clk_en) begin
            done_q <= done_d;
        end
    end
endmodule // csb_unit

// File: verilog/csb_consts.vh
// constants for the compare, skip and branch unit
`ifndef CSB_CONSTS_VH
`define CSB_CONSTS_VH
`define CSB_OP_NONE      4'h0
`define CSB_OP_SKIP_EQ   4'h1
`define CSB_OP_CMP_IMM   4'h2
`define CSB_OP_SKIP_RBC  4'h3
`define CSB_OP_SKIP_RBS  4'h4
`define CSB_OP_SKIP_IBC  4'h5
`define CSB_OP_SKIP_IBS  4'h6
`define CSB_OP_BR_SET    4'h7
`define CSB_OP_BR_CLR    4'h8
`define CSB_PC_STEP      12'h001
`define CSB_SKIP_ONE     12'h002
`define CSB_SKIP_TWO     12'h003
`define CSB_CYC_SEQ      2'h1
`define CSB_CYC_BR       2'h2
`define CSB_CYC_SKIP_ONE 2'h2
`define CSB_CYC_SKIP_TWO 2'h3
`define CSB_PC_RST       12'h000
`define CSB_FLAGS_RST    8'h00
`define CSB_CYC_RST      2'h0
`define CSB_FLAG_C      0
`define CSB_FLAG_Z      1
`define CSB_FLAG_N      2
`define CSB_FLAG_V      3
`define CSB_FLAG_S      4
`define CSB_FLAG_H      5
`define CSB_PC_W        12
`endif

// File: verilog/csb_flag_calc.v
// flag computation for a subtract-compare
`timescale 1ns/100ps
module csb_flag_calc (
    input  wire [7:0] op_a,      // minuend
    input  wire [7:0] op_b,      // subtrahend
    input  wire [7:0] flags_in,  // current flags
    output wire [7:0] flags_out  // flags after compare
);
    wire [7:0] diff;
    wire       c;
    wire       h;
    wire       v;
    wire       n;
    wire       z;
    assign diff = op_a - op_b;
    assign c = (~op_a[7] & op_b[7]) | (op_b[7] & diff[7]) | (diff[7] & ~op_a[7]);
    assign h = (~op_a[3] & op_b[3]) | (op_b[3] & diff[3]) | (diff[3] & ~op_a[3]);
    assign v = (op_a[7] & ~op_b[7] & ~diff[7]) | (~op_a[7] & op_b[7] & diff[7]);
    assign n = diff[7];
    assign z = (diff == 8'h00);
    assign flags_out = {flags_in[7:6], h, n ^ v, v, n, z, c};
endmodule // csb_flag_calc

// File: dv/csb_unit_monitor.sv
// port assertions for the compare, skip and branch unit
`timescale 1ns/100ps
module csb_unit_monitor (
    input wire        clk, rst_b, clk_en, ins_valid, next_two_word, done_q, busy, // control
    input wire [3:0]  ins_op,                                                     // operation
    input wire [7:0]  reg_d, reg_r, io_val, status_flags_q,                       // operands, flags
    input wire [2:0]  bit_sel,                                                    // bit or flag
    input wire [6:0]  offset_k,                                                   // branch offset
    input wire [11:0] pc_in, pc_q,                                                // program counter
    input wire [1:0]  cycles_q                                                    // cycle count
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire        tk    = clk_en && ins_valid && !busy;
    wire [11:0] k_ext = {{5{offset_k[6]}}, offset_k};
    AST_HOLD: assert property (!clk_en
        |=> $stable(pc_q) && $stable(status_flags_q) && $stable(cycles_q)) else $error("state moved while frozen");
    AST_SKIP_EQ: assert property (tk && ins_op == 4'h1 && reg_d == reg_r && !next_two_word
        |=> pc_q == $past(pc_in) + 12'h002 ##1 done_q) else $error("equal skip wrong");
    AST_CMP_IMM: assert property (tk && ins_op == 4'h2
        |=> status_flags_q[1] == ($past(reg_d) == $past(reg_r))) else $error("compare zero flag wrong");
    AST_RBC: assert property (tk && ins_op == 4'h3 && !reg_d[bit_sel] && next_two_word
        |=> cycles_q == 2'h3 ##2 done_q) else $error("bit clear skip timing wrong");
    AST_IBC: assert property (tk && ins_op == 4'h5 && !io_val[bit_sel]
        |=> pc_q == $past(pc_in) + {10'h000, cycles_q} && cycles_q != 2'h1) else $error("io clear skip wrong");
    AST_IBS: assert property (tk && ins_op == 4'h6 && io_val[bit_sel]
        |=> pc_q == $past(pc_in) + {10'h000, cycles_q} && $stable(status_flags_q)) else $error("io set skip wrong");
    AST_BRS: assert property (tk && ins_op == 4'h7 && status_flags_q[bit_sel]
        |=> pc_q == $past(pc_in) + $past(k_ext) + 12'h001) else $error("branch on set wrong");
    AST_BRC: assert property (tk && ins_op == 4'h8 && !status_flags_q[bit_sel]
        |=> pc_q == $past(pc_in) + $past(k_ext) + 12'h001 ##1 done_q) else $error("branch on clear wrong");
    AST_RBS: assert property (tk && ins_op == 4'h4 && reg_d[bit_sel] && !next_two_word
        |=> pc_q == $past(pc_in) + 12'h002 && $stable(status_flags_q)) else $error("bit set skip wrong");
endmodule // csb_unit_monitor
bind csb_unit csb_unit_monitor mon (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .ins_valid(ins_valid),
    .next_two_word(next_two_word), .done_q(done_q), .busy(busy), .ins_op(ins_op), .reg_d(reg_d), .reg_r(reg_r),
    .io_val(io_val), .status_flags_q(status_flags_q), .bit_sel(bit_sel), .offset_k(offset_k), .pc_in(pc_in),
    .pc_q(pc_q), .cycles_q(cycles_q));

// File: dv/csb_unit_tb_top.sv
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/100ps
module csb_unit_tb_top;
    logic        clk = 0, rst_b = 0, clk_en = 1, ins_valid = 0, next_two_word = 0, done_q, busy;
    logic [3:0]  ins_op = 4'h0;
    logic [7:0]  reg_d = 8'h00, reg_r = 8'h00, io_val = 8'h00, status_flags_q;
    logic [2:0]  bit_sel = 3'h0;
    logic [6:0]  offset_k = 7'h00;
    logic [11:0] pc_in = 12'h100, pc_q;
    logic [1:0]  cycles_q;
    int          num_errors = 0, total_checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    csb_unit uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .ins_valid(ins_valid), .ins_op(ins_op), .reg_d(reg_d),
        .reg_r(reg_r), .io_val(io_val), .bit_sel(bit_sel), .offset_k(offset_k), .next_two_word(next_two_word),
        .pc_in(pc_in), .pc_q(pc_q), .status_flags_q(status_flags_q), .cycles_q(cycles_q), .done_q(done_q), .busy(busy));
    task report_and_stop;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(string n, logic [11:0] e, logic [11:0] g);
        total_checks++;
        if (e !== g) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one instruction; done must pulse exactly after the expected cycle count
    task go(logic [3:0] op, logic [7:0] d, r, io, logic [2:0] b, logic [6:0] k, logic nt, logic [11:0] epc,
        logic [1:0] ec);
        @(negedge clk);
        {ins_op, reg_d, reg_r, io_val, bit_sel, offset_k, next_two_word, ins_valid} = {op, d, r, io, b, k, nt, 1'b1};
        @(negedge clk);
        ins_valid = 0;
        chk("pc", epc, pc_q);
        chk("cycles", {10'h000, ec}, {10'h000, cycles_q});
        chk("busy", {11'h000, ec != 2'h1}, {11'h000, busy});
        repeat (ec - 1) @(negedge clk);
        chk("done", 12'h001, {11'h000, done_q});
    endtask
    task t_compare_skip_equal;
        go(4'h1, 8'h5A, 8'h5A, 8'h00, 3'h0, 7'h00, 0, 12'h102, 2'h2);
        go(4'h1, 8'h5A, 8'h5A, 8'h00, 3'h0, 7'h00, 1, 12'h103, 2'h3);
        go(4'h1, 8'h5A, 8'h5B, 8'h00, 3'h0, 7'h00, 1, 12'h101, 2'h1);
    endtask
    task t_bits;
        go(4'h3, 8'hEF, 8'h00, 8'h00, 3'h4, 7'h00, 1, 12'h103, 2'h3);
        go(4'h3, 8'h10, 8'h00, 8'h00, 3'h4, 7'h00, 0, 12'h101, 2'h1);
        go(4'h4, 8'h10, 8'h00, 8'h00, 3'h4, 7'h00, 0, 12'h102, 2'h2);
        go(4'h5, 8'h00, 8'h00, 8'h7F, 3'h7, 7'h00, 1, 12'h103, 2'h3);
        go(4'h6, 8'h00, 8'h00, 8'h80, 3'h7, 7'h00, 0, 12'h102, 2'h2);
    endtask
    task t_flags;
        go(4'h2, 8'h05, 8'h05, 8'h00, 3'h0, 7'h00, 0, 12'h101, 2'h1);
        chk("flags", 12'h002, {4'h0, status_flags_q});
        go(4'h7, 8'h00, 8'h00, 8'h00, 3'h1, 7'h7D, 0, 12'h0FE, 2'h2);
        go(4'h8, 8'h00, 8'h00, 8'h00, 3'h1, 7'h05, 0, 12'h101, 2'h1);
        go(4'h2, 8'h03, 8'h05, 8'h00, 3'h0, 7'h00, 0, 12'h101, 2'h1);
        chk("flags", 12'h035, {4'h0, status_flags_q});
        go(4'h8, 8'h00, 8'h00, 8'h00, 3'h1, 7'h05, 0, 12'h106, 2'h2);
    endtask
    // clock enable low freezes state, unknown codes are dropped, reset mid-run
    task t_hold;
        @(negedge clk);
        clk_en = 0;
        {ins_op, reg_d, bit_sel, next_two_word, ins_valid} = {4'h4, 8'h01, 3'h0, 1'b0, 1'b1};
        repeat (2) @(negedge clk);
        chk("hold pc", 12'h106, pc_q);
        chk("hold busy", 12'h000, {11'h000, busy});
        clk_en = 1;
        ins_op = 4'h9;
        @(negedge clk);
        ins_valid = 0;
        chk("refused pc", 12'h106, pc_q);
        chk("refused done", 12'h000, {11'h000, done_q});
        rst_b = 0;
        @(negedge clk);
        chk("reset pc", 12'h000, pc_q);
        chk("reset flags", 12'h000, {4'h0, status_flags_q});
        rst_b = 1;
        go(4'h4, 8'h01, 8'h00, 8'h00, 3'h0, 7'h00, 0, 12'h102, 2'h2);
    endtask
    // timeout fails the run at 2000 cycles; go never waits on done, so a missing pulse fails the done check
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1;
        t_compare_skip_equal;
        t_bits;
        t_flags;
        t_hold;
        report_and_stop;
    end
endmodule // csb_unit_tb_top
